// ==== core/tmrwv_top.sv ====
// one 16-bit timer channel in waveform mode behind an avalon-mm slave
// Function
// - soft-reset command clears every channel register; zero does nothing
// - clock-enable acts only with clock-disable zero; disable always wins
// - software trigger zeroes and starts the counter on next valid edge
// - clock source: core clock /2,/8,/32,/128,/1024 or external lines 0-2
// - clock invert selects counting on falling instead of rising edges
// - burst field ANDs the counter clock with none or external line 0-2
// - period-stop halts counter at period match; only a trigger restarts
// - period match asking both trigger and stop just stops
// - period-clock-off disables clock and stops; only clock-enable reopens
// - event edge field picks none, rising, falling or both edges
// - each event sets event flag, maybe triggers, drives pin actions
// - event source field picks pin B or external line 0-2
// - pin B source means single mode: B input, B actions and compare B off
// - event trigger enable decides whether events restart the counter
// - period-trigger bit makes period match restart the counter
// - pin A set/clear/toggle on soft trigger, event, period, compare A
// - pin A priority: soft trigger, event, period, compare A
// - pin B same actions with compare B, only while B is an output
// - pin B priority: soft trigger, event, period, compare B
// - mode-select one means waveform mode with pin A driven
// - counter wraps 0xffff to zero and reports overflow
`timescale 1ns/100ps
`include "tmrwv_params.svh"
module tmrwv_top (
  // clock, reset, freeze
  input wire logic REF_CLK,
  input wire logic RSTN,
  input wire logic CE,
  // avalon-mm slave
  input wire logic [7:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // external clock lines
  input wire logic [2:0] EXT_CLOCK_LINE,
  // waveform pins
  output logic WAVEFORM_PIN_A_O,
  output logic WAVEFORM_PIN_A_OE,
  input wire logic WAVEFORM_PIN_B_I,
  output logic WAVEFORM_PIN_B_O,
  output logic WAVEFORM_PIN_B_OE
);
  default clocking dclk @(posedge REF_CLK);
  endclocking
  default disable iff (!RSTN);

  // ----------------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------------
  logic req;
  logic commit;
  logic wr;
  logic sel_cmd;
  logic sel_mode;
  logic sel_stat;
  logic sel_cnt;
  logic sel_cmp;
  logic [1:0] cmp_idx;
  logic [31:0] rd_word;
  logic [31:0] stat_word;

  assign req = AVS_READ | AVS_WRITE;
  // the write lands and status clears at the edge where waitrequest is low
  assign commit = req & ~AVS_WAITREQUEST;
  assign wr = AVS_WRITE & commit;
  assign sel_cmd = AVS_ADDRESS == `TMRWV_OFS_CMD;
  assign sel_mode = AVS_ADDRESS == `TMRWV_OFS_MODE;
  assign sel_stat = AVS_ADDRESS == `TMRWV_OFS_STAT;
  assign sel_cnt = AVS_ADDRESS == `TMRWV_OFS_CNT;
  assign sel_cmp = (AVS_ADDRESS >= `TMRWV_OFS_CMPA) && (AVS_ADDRESS <= `TMRWV_OFS_PER)
                   && (AVS_ADDRESS[1:0] == 2'h0);
  assign cmp_idx = 2'((AVS_ADDRESS - `TMRWV_OFS_CMPA) >> 2);

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA <= 32'h0;
    end else if (CE) begin
      AVS_WAITREQUEST <= ~(req & AVS_WAITREQUEST);
      if (AVS_READ & AVS_WAITREQUEST) begin
        AVS_READDATA <= rd_word;
      end
    end
  end

  // ----------------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------------
  logic cmd_ok;
  logic srst;
  logic clock_enable_cmd_cmd;
  logic clock_disable_cmd_cmd;
  logic sw_ev;

  assign cmd_ok = wr & sel_cmd & AVS_BYTEENABLE[0];
  assign srst = cmd_ok & AVS_WRITEDATA[`TMRWV_CMD_SRST];
  assign clock_disable_cmd_cmd = cmd_ok & AVS_WRITEDATA[`TMRWV_CMD_CLOCK_DISABLE_CMD] & ~srst;
  assign clock_enable_cmd_cmd = cmd_ok & AVS_WRITEDATA[`TMRWV_CMD_CLOCK_ENABLE_CMD]
                     & ~AVS_WRITEDATA[`TMRWV_CMD_CLOCK_DISABLE_CMD] & ~srst;
  assign sw_ev = cmd_ok & AVS_WRITEDATA[`TMRWV_CMD_SOFTWARE_TRIGGER_CMD] & ~srst;

  // ----------------------------------------------------------------------
  // mode and compare registers
  // ----------------------------------------------------------------------
  logic [31:0] mode;
  logic [15:0] cmp_reg [`TMRWV_CMP_NUM];
  logic [2:0] clock_source_sel;
  logic clock_invert;
  logic [1:0] burst;
  logic [1:0] edg;
  logic [1:0] evt;
  logic wave;
  logic dual;

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      mode <= `TMRWV_MODE_RST;
    end else if (CE) begin
      if (srst) begin
        mode <= `TMRWV_MODE_RST;
      end else if (wr & sel_mode) begin
        for (int i = 0; i < 4; i++) begin
          if (AVS_BYTEENABLE[i]) begin
            mode[8*i +: 8] <= AVS_WRITEDATA[8*i +: 8];
          end
        end
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < `TMRWV_CMP_NUM; g++) begin : g_cmp
      always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
          cmp_reg[g] <= 16'h0;
        end else if (CE) begin
          if (srst) begin
            cmp_reg[g] <= 16'h0;
          end else if (wr & sel_cmp & (cmp_idx == 2'(g))) begin
            if (AVS_BYTEENABLE[0]) cmp_reg[g][7:0] <= AVS_WRITEDATA[7:0];
            if (AVS_BYTEENABLE[1]) cmp_reg[g][15:8] <= AVS_WRITEDATA[15:8];
          end
        end
      end
    end
  endgenerate

  assign clock_source_sel = mode[`TMRWV_MD_CLOCK_SOURCE_SEL +: 3];
  assign clock_invert = mode[`TMRWV_MD_CLOCK_INVERT];
  assign burst = mode[`TMRWV_MD_BURST +: 2];
  assign edg = mode[`TMRWV_MD_EDG +: 2];
  assign evt = mode[`TMRWV_MD_EVT +: 2];
  assign wave = mode[`TMRWV_MD_WAVE];
  assign dual = evt != 2'h0;

  // ----------------------------------------------------------------------
  // pin synchronisers and external event
  // ----------------------------------------------------------------------
  logic [3:0] sync1;
  logic [3:0] sync2;
  logic ev_prev;
  logic ev_src;
  logic ext_ev;

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      sync1 <= 4'h0;
      sync2 <= 4'h0;
      ev_prev <= 1'b0;
    end else if (CE) begin
      sync1 <= {WAVEFORM_PIN_B_I, EXT_CLOCK_LINE};
      sync2 <= sync1;
      ev_prev <= ev_src;
    end
  end

  assign ev_src = tmrwv_pkg::pick_line(evt, sync2[2:0], sync2[3]);
  // bit 0 of the edge field enables rising, bit 1 falling
  assign ext_ev = (edg[0] & ev_src & ~ev_prev)
                  | (edg[1] & ~ev_src & ev_prev);

  // ----------------------------------------------------------------------
  // counter clock
  // ----------------------------------------------------------------------
  logic tick;

  tmrwv_clksel u_clksel (
    .clk(REF_CLK),
    .rstn(RSTN),
    .ce(CE),
    .srst(srst),
    .clock_source_sel(clock_source_sel),
    .clock_invert(clock_invert),
    .burst(burst),
    .xc_s(sync2[2:0]),
    .tick(tick)
  );

  // ----------------------------------------------------------------------
  // counter, triggers, compare events
  // ----------------------------------------------------------------------
  logic clk_en;
  logic trig_pend;
  tmrwv_pkg::tmrwv_run_t run;
  logic [15:0] cnt;
  logic step;
  logic [15:0] next_cnt;
  logic trig_req;
  logic per_stop;
  logic per_ev;
  logic cpa_ev;
  logic cpb_ev;
  logic ovf_ev;

  // a stopping period match swallows its own trigger
  assign per_stop = per_ev & (mode[`TMRWV_MD_STOP] | mode[`TMRWV_MD_CLKOFF]);
  assign trig_req = sw_ev
                    | (ext_ev & mode[`TMRWV_MD_EVENT_TRIGGER_ENABLE])
                    | (per_ev & mode[`TMRWV_MD_PERTRG] & ~per_stop);
  assign step = tick & clk_en & (trig_pend | (run == tmrwv_pkg::RUN_ON));
  assign next_cnt = trig_pend ? 16'h0 : cnt + 16'h1;

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      clk_en <= 1'b0;
    end else if (CE) begin
      if (srst | clock_disable_cmd_cmd) begin
        clk_en <= 1'b0;
      end else if (clock_enable_cmd_cmd) begin
        clk_en <= 1'b1;
      end else if (per_ev & mode[`TMRWV_MD_CLKOFF]) begin
        clk_en <= 1'b0;
      end
    end
  end

  // a trigger waits for the next valid edge, and only while clocked
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      trig_pend <= 1'b0;
    end else if (CE) begin
      if (srst | ~clk_en) begin
        trig_pend <= 1'b0;
      end else if (trig_req) begin
        trig_pend <= 1'b1;
      end else if (tick) begin
        trig_pend <= 1'b0;
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      run <= tmrwv_pkg::RUN_IDLE;
      cnt <= 16'h0;
    end else if (CE) begin
      if (srst) begin
        run <= tmrwv_pkg::RUN_IDLE;
        cnt <= 16'h0;
      end else if (step) begin
        run <= tmrwv_pkg::RUN_ON;
        cnt <= next_cnt;
      end else if (per_stop) begin
        run <= tmrwv_pkg::RUN_IDLE;
      end
    end
  end

  // compares see the value the counter just took
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      per_ev <= 1'b0;
      cpa_ev <= 1'b0;
      cpb_ev <= 1'b0;
      ovf_ev <= 1'b0;
    end else if (CE) begin
      per_ev <= ~srst & step & (next_cnt == cmp_reg[2]);
      cpa_ev <= ~srst & step & (next_cnt == cmp_reg[0]);
      cpb_ev <= ~srst & step & dual & (next_cnt == cmp_reg[1]);
      ovf_ev <= ~srst & step & ~trig_pend & (cnt == 16'hffff);
    end
  end

  // ----------------------------------------------------------------------
  // waveform pins
  // ----------------------------------------------------------------------
  tmrwv_pin_act u_pin_a (
    .clk(REF_CLK),
    .rstn(RSTN),
    .ce(CE),
    .srst(srst),
    .en(wave),
    .ev({sw_ev, ext_ev, per_ev, cpa_ev}),
    .act(mode[`TMRWV_MD_ACT_A +: 8]),
    .pin(WAVEFORM_PIN_A_O)
  );

  tmrwv_pin_act u_pin_b (
    .clk(REF_CLK),
    .rstn(RSTN),
    .ce(CE),
    .srst(srst),
    .en(wave & dual),
    .ev({sw_ev, ext_ev, per_ev, cpb_ev}),
    .act(mode[`TMRWV_MD_ACT_B +: 8]),
    .pin(WAVEFORM_PIN_B_O)
  );

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      WAVEFORM_PIN_A_OE <= 1'b0;
      WAVEFORM_PIN_B_OE <= 1'b0;
    end else if (CE) begin
      WAVEFORM_PIN_A_OE <= ~srst & wave;
      WAVEFORM_PIN_B_OE <= ~srst & wave & dual;
    end
  end

  // ----------------------------------------------------------------------
  // status flags, cleared by a status read
  // ----------------------------------------------------------------------
  logic [4:0] flags;
  logic [4:0] flag_set;
  logic [4:0] flag_clr;

  assign flag_set = {ext_ev, per_ev, cpb_ev, cpa_ev, ovf_ev};
  // only what the read returned is cleared, so a late event survives
  assign flag_clr = (AVS_READ & commit & sel_stat) ?
                    {AVS_READDATA[`TMRWV_ST_ETRG], AVS_READDATA[`TMRWV_ST_CPC],
                     AVS_READDATA[`TMRWV_ST_CPB], AVS_READDATA[`TMRWV_ST_CPA],
                     AVS_READDATA[`TMRWV_ST_OVF]} : 5'h0;

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      flags <= 5'h0;
    end else if (CE) begin
      flags <= srst ? 5'h0 : ((flags & ~flag_clr) | flag_set);
    end
  end

  always_comb begin
    stat_word = 32'h0;
    stat_word[`TMRWV_ST_OVF] = flags[0];
    stat_word[`TMRWV_ST_CPA] = flags[1];
    stat_word[`TMRWV_ST_CPB] = flags[2];
    stat_word[`TMRWV_ST_CPC] = flags[3];
    stat_word[`TMRWV_ST_ETRG] = flags[4];
    stat_word[`TMRWV_ST_CLKSTA] = clk_en;
    stat_word[`TMRWV_ST_MIRA] = WAVEFORM_PIN_A_O;
    stat_word[`TMRWV_ST_MIRB] = dual ? WAVEFORM_PIN_B_O : sync2[3];
  end

  // command register is write-only and reads as zero, as does any hole
  assign rd_word = sel_mode ? mode :
                   sel_stat ? stat_word :
                   sel_cnt ? {16'h0, cnt} :
                   sel_cmp ? {16'h0, cmp_reg[cmp_idx]} : 32'h0;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  chk_srst_clears: assert property (
    CE && srst |=> mode == `TMRWV_MODE_RST && !clk_en && cnt == 16'h0 && flags == 5'h0)
    else $error("soft reset left state behind");

  chk_clk_enable: assert property (
    CE && clock_enable_cmd_cmd |=> clk_en && ($past(clk_en) || $stable(cnt)))
    else $error("clock enable command ignored");

  chk_clk_disable: assert property (
    CE && clock_disable_cmd_cmd |=> !clk_en ##1 !(CE && step))
    else $error("clock disable command ignored");

  chk_trig_zero: assert property (
    CE && !srst && step && trig_pend |=> cnt == 16'h0 && run == tmrwv_pkg::RUN_ON)
    else $error("trigger did not restart counter at zero");

  chk_stop_match: assert property (
    CE && !srst && per_stop && !step |=> run == tmrwv_pkg::RUN_IDLE && !trig_pend)
    else $error("stopping period match still triggered");

  chk_clkoff_match: assert property (
    CE && !cmd_ok && per_ev && mode[`TMRWV_MD_CLKOFF] |=> !clk_en)
    else $error("period match did not gate the clock");

  chk_b_input: assert property (
    CE && evt == 2'h0 |=> !WAVEFORM_PIN_B_OE && !cpb_ev)
    else $error("pin b driven in single mode");

  chk_ovf_wrap: assert property (
    CE && !srst && step && !trig_pend && cnt == 16'hffff |=> cnt == 16'h0 && ovf_ev)
    else $error("counter wrap not reported");

  chk_count_step: assert property (
    CE && !srst && step && !trig_pend |=> cnt == 16'($past(cnt) + 16'h1))
    else $error("counter did not step by one");

  chk_ack_one: assert property (
    CE && req && AVS_WAITREQUEST |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST)
    else $error("bus answer not one cycle");
endmodule : tmrwv_top

// ==== include/tmrwv_params.svh ====
// offsets, field positions, reset values and divider taps of the timer channel
`ifndef TMRWV_PARAMS_SVH
`define TMRWV_PARAMS_SVH
// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define TMRWV_OFS_CMD 8'h60
`define TMRWV_OFS_MODE 8'h64
`define TMRWV_OFS_STAT 8'h70
`define TMRWV_OFS_CNT 8'h80
`define TMRWV_OFS_CMPA 8'h84
`define TMRWV_OFS_PER 8'h8c
`define TMRWV_CMP_NUM 3
// ----------------------------------------------------------------------
// command bits
// ----------------------------------------------------------------------
`define TMRWV_CMD_SRST 0
`define TMRWV_CMD_CLOCK_ENABLE_CMD 1
`define TMRWV_CMD_CLOCK_DISABLE_CMD 2
`define TMRWV_CMD_SOFTWARE_TRIGGER_CMD 3
// ----------------------------------------------------------------------
// mode fields (lsb positions)
// ----------------------------------------------------------------------
`define TMRWV_MD_CLOCK_SOURCE_SEL 0
`define TMRWV_MD_CLOCK_INVERT 3
`define TMRWV_MD_BURST 4
`define TMRWV_MD_STOP 6
`define TMRWV_MD_CLKOFF 7
`define TMRWV_MD_EDG 8
`define TMRWV_MD_EVT 10
`define TMRWV_MD_EVENT_TRIGGER_ENABLE 12
`define TMRWV_MD_PERTRG 14
`define TMRWV_MD_WAVE 15
`define TMRWV_MD_ACT_A 16
`define TMRWV_MD_ACT_B 24
`define TMRWV_MODE_RST 32'h0000_0000
// ----------------------------------------------------------------------
// status bits
// ----------------------------------------------------------------------
`define TMRWV_ST_OVF 0
`define TMRWV_ST_CPA 2
`define TMRWV_ST_CPB 3
`define TMRWV_ST_CPC 4
`define TMRWV_ST_ETRG 7
`define TMRWV_ST_CLKSTA 8
`define TMRWV_ST_MIRA 9
`define TMRWV_ST_MIRB 10
// ----------------------------------------------------------------------
// prescaler
// ----------------------------------------------------------------------
`define TMRWV_DIV_W 10
`define TMRWV_TAP_2 0
`define TMRWV_TAP_8 2
`define TMRWV_TAP_32 4
`define TMRWV_TAP_128 6
`define TMRWV_TAP_1024 9
`endif

// ==== include/tmrwv_pkg.sv ====
// types and the line-select function of the timer channel
package tmrwv_pkg;
  typedef enum logic [1:0] {
    ACT_NONE = 2'h0,
    ACT_SET = 2'h1,
    ACT_CLR = 2'h2,
    ACT_TGL = 2'h3
  } tmrwv_act_t;

  typedef enum logic {
    RUN_IDLE = 1'b0,
    RUN_ON = 1'b1
  } tmrwv_run_t;

  // code 0 picks the default, codes 1..3 pick external line 0..2
  function automatic logic pick_line(input logic [1:0] code, input logic [2:0] lines,
                                     input logic dflt);
    case (code)
      2'h1: pick_line = lines[0];
      2'h2: pick_line = lines[1];
      2'h3: pick_line = lines[2];
      default: pick_line = dflt;
    endcase
  endfunction : pick_line
endpackage : tmrwv_pkg

// ==== core/tmrwv_clksel.sv ====
// counter clock prescaler, source select, burst gate, inversion, edge detect
`timescale 1ns/100ps
`include "tmrwv_params.svh"
module tmrwv_clksel (
  // clocking
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic srst,
  // configuration and synchronised lines
  input wire logic [2:0] clock_source_sel,
  input wire logic clock_invert,
  input wire logic [1:0] burst,
  input wire logic [2:0] xc_s,
  // one-cycle pulse per valid counter clock edge
  output logic tick
);
  logic [`TMRWV_DIV_W-1:0] div;
  logic prev;
  logic src;
  logic gated;
  logic lvl;

  // core clock taps give /2 .. /1024 as square waves
  assign src = (clock_source_sel == 3'h0) ? div[`TMRWV_TAP_2] :
               (clock_source_sel == 3'h1) ? div[`TMRWV_TAP_8] :
               (clock_source_sel == 3'h2) ? div[`TMRWV_TAP_32] :
               (clock_source_sel == 3'h3) ? div[`TMRWV_TAP_128] :
               (clock_source_sel == 3'h4) ? div[`TMRWV_TAP_1024] :
               xc_s[clock_source_sel[1:0] - 2'h1];
  assign gated = src & tmrwv_pkg::pick_line(burst, xc_s, 1'b1);
  assign lvl = gated ^ clock_invert;
  assign tick = lvl & ~prev;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      div <= '0;
      prev <= 1'b0;
    end else if (ce) begin
      div <= srst ? '0 : div + `TMRWV_DIV_W'(1);
      prev <= srst ? 1'b0 : lvl;
    end
  end
endmodule : tmrwv_clksel

// ==== core/tmrwv_pin_act.sv ====
// prioritised set/clear/toggle of one waveform pin
`timescale 1ns/100ps
module tmrwv_pin_act (
  // clocking
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic srst,
  // events: [3] soft trigger, [2] ext event, [1] period, [0] compare
  input wire logic en,
  input wire logic [3:0] ev,
  input wire logic [7:0] act,
  // pin level
  output logic pin
);
  logic [3:0] hit;
  tmrwv_pkg::tmrwv_act_t sel;
  logic next_pin;

  // an event whose field is none does not mask a lower one
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_hit
      assign hit[g] = ev[g] & (act[2*g +: 2] != 2'h0);
    end
  endgenerate

  assign sel = hit[3] ? tmrwv_pkg::tmrwv_act_t'(act[7:6]) :
               hit[2] ? tmrwv_pkg::tmrwv_act_t'(act[5:4]) :
               hit[1] ? tmrwv_pkg::tmrwv_act_t'(act[3:2]) :
               hit[0] ? tmrwv_pkg::tmrwv_act_t'(act[1:0]) :
               tmrwv_pkg::ACT_NONE;

  always_comb begin
    case (sel)
      tmrwv_pkg::ACT_SET: next_pin = 1'b1;
      tmrwv_pkg::ACT_CLR: next_pin = 1'b0;
      tmrwv_pkg::ACT_TGL: next_pin = ~pin;
      default: next_pin = pin;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pin <= 1'b0;
    end else if (ce) begin
      pin <= srst ? 1'b0 : (en ? next_pin : pin);
    end
  end

  chk_sw_wins: assert property (@(posedge clk) disable iff (!rstn)
    (ce && !srst && en && ev[3] && act[7:6] != 2'h0) |=>
      (pin == ($past(act[7:6]) == 2'h3 ? !$past(pin) : $past(act[7:6]) == 2'h1)))
    else $error("soft trigger action did not win");
endmodule : tmrwv_pin_act

// ==== tb/tmrwv_far_end.sv ====
// model of the circuitry wired to the clock lines and waveform pin b
`timescale 1ns/100ps
module tmrwv_far_end (
  // clocking
  input wire logic clk,
  input wire logic rstn,
  // commanded levels from the bench
  input wire logic [2:0] line_req,
  input wire logic pin_b_drv,
  // pin b as driven by the channel
  input wire logic pin_b_o,
  input wire logic pin_b_oe,
  // levels seen by the channel
  output logic [2:0] ext_line,
  output logic pin_b_level
);
  // lines move only just after an edge, like a real synchronous source
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ext_line <= 3'h0;
    end else begin
      ext_line <= line_req;
    end
  end
  // the channel wins the wire whenever it drives pin b
  assign pin_b_level = pin_b_oe ? pin_b_o : pin_b_drv;
endmodule : tmrwv_far_end

// ==== tb/test_timer_waveform_channel_control.sv ====
// self-checking bench of the timer channel in waveform mode
`timescale 1ns/100ps
module test_timer_waveform_channel_control;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] adr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic wait_req;
  logic [2:0] line_req = 3'h0;
  logic [2:0] ext_line;
  logic pa_o, pa_oe, pb_o, pb_oe, pb_lvl;
  logic [31:0] q;
  int bad_count = 0;
  int n_checks = 0;
  initial begin
    forever #4 clk = ~clk;
  end
  tmrwv_top i_tmrwv_top (.REF_CLK(clk), .RSTN(rstn), .CE(1'b1), .AVS_ADDRESS(adr),
    .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(4'hf),
    .AVS_READDATA(rdat), .AVS_WAITREQUEST(wait_req), .EXT_CLOCK_LINE(ext_line),
    .WAVEFORM_PIN_A_O(pa_o), .WAVEFORM_PIN_A_OE(pa_oe), .WAVEFORM_PIN_B_I(pb_lvl),
    .WAVEFORM_PIN_B_O(pb_o), .WAVEFORM_PIN_B_OE(pb_oe));
  tmrwv_far_end i_tmrwv_far_end (.clk(clk), .rstn(rstn), .line_req(line_req),
    .pin_b_drv(1'b1), .pin_b_o(pb_o), .pin_b_oe(pb_oe), .ext_line(ext_line),
    .pin_b_level(pb_lvl));
  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      $display("Error %0t: %s got %h expected %h", $time, what, got, exp);
      bad_count++;
    end
  endtask : chk
  // one avalon access; holds everything until waitrequest is seen low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    adr <= a;
    wr <= w;
    rd <= !w;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wait_req !== 1'b0 && n < 50);
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
    if (n >= 50) begin
      bad_count++;
      final_report();
    end
  endtask : bus
  // poll a register until masked bits match, bounded
  task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
    int n;
    n = 0;
    do begin
      bus(1'b0, a, 32'h0);
      n++;
    end while ((q & m) !== v && n < 200);
    chk(q & m, v, "poll");
  endtask : poll
  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_regs;
    bus(1'b0, 8'h64, 32'h0);
    chk(q, 32'h0, "mode reset");
    bus(1'b0, 8'h90, 32'h0);
    chk(q, 32'h0, "unmapped read");
    bus(1'b1, 8'h64, 32'ha5c3_f0ff);
    bus(1'b0, 8'h64, 32'h0);
    chk(q, 32'ha5c3_f0ff, "mode readback");
    $display("test regs done");
  endtask : t_regs
  task automatic t_soft_trig;
    // wave, dual mode, soft trigger sets a and toggles b
    bus(1'b1, 8'h64, 32'hc040_8400);
    bus(1'b1, 8'h60, 32'h2);
    bus(1'b1, 8'h60, 32'h8);
    bus(1'b0, 8'h70, 32'h0);
    chk({pa_oe, pa_o, pb_oe, pb_o}, 4'hf, "soft trigger pins");
    chk(q & 32'h700, 32'h700, "clock and mirrors");
    $display("test soft trigger done");
  endtask : t_soft_trig
  task automatic t_clk_cmd;
    bus(1'b1, 8'h60, 32'h6);
    bus(1'b0, 8'h70, 32'h0);
    chk(q & 32'h100, 32'h0, "enable with disable");
    bus(1'b1, 8'h60, 32'h2);
    bus(1'b0, 8'h70, 32'h0);
    chk(q & 32'h100, 32'h100, "enable alone");
    $display("test clock commands done");
  endtask : t_clk_cmd
  task automatic t_period_off;
    // core clock /2, period match turns the clock off and stops
    bus(1'b1, 8'h64, 32'h0000_8480);
    bus(1'b1, 8'h8c, 32'h3);
    bus(1'b1, 8'h60, 32'h2);
    bus(1'b1, 8'h60, 32'h8);
    poll(8'h80, 32'hffff, 32'h3);
    bus(1'b0, 8'h70, 32'h0);
    chk(q & 32'h110, 32'h10, "period match clock off");
    bus(1'b0, 8'h80, 32'h0);
    chk(q, 32'h3, "counter stopped");
    bus(1'b1, 8'h60, 32'h8);
    bus(1'b0, 8'h80, 32'h0);
    chk(q, 32'h3, "trigger while clock off");
    $display("test period clock off done");
  endtask : t_period_off
  task automatic t_event;
    // rising edge on line 0 toggles pin a
    bus(1'b1, 8'h64, 32'h0030_8500);
    line_req <= 3'h1;
    poll(8'h70, 32'h80, 32'h80);
    bus(1'b0, 8'h70, 32'h0);
    chk({pa_oe, pa_o}, 2'h3, "event toggles a");
    line_req <= 3'h0;
    $display("test event done");
  endtask : t_event
  task automatic t_soft_reset;
    bus(1'b1, 8'h60, 32'h1);
    bus(1'b0, 8'h64, 32'h0);
    chk(q, 32'h0, "mode after soft reset");
    chk({pa_oe, pa_o}, 2'h0, "pin a after soft reset");
    bus(1'b0, 8'h8c, 32'h0);
    chk(q, 32'h0, "period after soft reset");
    $display("test soft reset done");
  endtask : t_soft_reset
  task automatic t_period_trig;
    // period match restarts the counter; pin b is an input in single mode
    bus(1'b1, 8'h64, 32'h000c_c000);
    bus(1'b1, 8'h8c, 32'h3);
    bus(1'b1, 8'h60, 32'h2);
    bus(1'b1, 8'h60, 32'h8);
    poll(8'h80, 32'hffff, 32'h3);
    repeat (6) begin
      bus(1'b0, 8'h80, 32'h0);
      chk(q & 32'hfffc, 32'h0, "period trigger restart");
    end
    bus(1'b0, 8'h70, 32'h0);
    chk(q & 32'h510, 32'h510, "single mode status");
    chk(pb_oe, 1'b0, "pin b not driven");
    $display("test period trigger done");
  endtask : t_period_trig
  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    t_regs();
    t_soft_trig();
    t_clk_cmd();
    t_period_off();
    t_soft_reset();
    t_event();
    t_soft_reset();
    t_period_trig();
    final_report();
  end
endmodule : test_timer_waveform_channel_control
